/* File: core/nip_consts.vh */
// Constants for the normal interrupt pending block
`ifndef NIP_CONSTS_VH
`define NIP_CONSTS_VH
`define NIP_NUM_SRC        32
`define NIP_OFS_PENDING    8'h00
`define NIP_OFS_ENABLE     8'h04
`define NIP_OFS_STATUS     8'h08
`define NIP_OFS_MASK       8'h0C
`define NIP_RST_PENDING    32'h0000_0000
`define NIP_RST_ENABLE     32'h0000_0000
`define NIP_RST_STATUS     32'h0000_0000
`define NIP_RST_MASK       32'h0000_0000
`define NIP_ADDR_BITS      8
`define NIP_HTRANS_NONSEQ  2'h2
`define NIP_HTRANS_SEQ     2'h3
`endif

/* File: core/nip_sync.v */
// Two-flop synchroniser for the interrupt source lines
`timescale 1ns/1ps
`default_nettype none
module nip_sync (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire [31:0] async_in,
    output reg  [31:0] sync_out
);
    reg [31:0] meta;

    // First stage read only by second stage
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta     <= 32'h0000_0000;
            sync_out <= 32'h0000_0000;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule // nip_sync
`default_nettype wire

/* File: core/nip_top.v */
// Normal interrupt pending logic with AHB-Lite register slave
// Summary of operation
// - One pending flag per source sits at bits 31 down to 0, bit x for source x.
// - A pending flag reads 0 with no request and 1 with a normal request pending.
// - The normal request output is high while any asserted source has its enable set.
// - Each pending flag is the AND of its live source line and its enable flag.
`timescale 1ns/1ps
`default_nettype none
`include "nip_consts.vh"
module nip_top (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire [31:0] irq_src,
    output reg         normal_irq_req,
    output reg         irq
);
    // Architectural registers
    reg  [31:0] normal_irq_pending;
    reg  [31:0] normal_enable;
    reg  [31:0] irq_status;
    reg  [31:0] irq_mask;

    // Write address held over into the data phase
    reg         wr_pend;
    reg  [7:0]  wr_addr;

    // Values each register takes at the coming edge
    reg  [31:0] next_hrdata;
    reg  [31:0] next_enable;
    reg  [31:0] next_mask;
    reg  [31:0] next_status;
    reg         next_wr_pend;
    reg  [7:0]  next_wr_addr;
    reg         next_req;
    reg         next_irq;

    // Source path and bus decode
    wire [31:0] src_sync;
    wire [31:0] next_pending;
    wire [31:0] rise;
    wire        take;
    wire        take_rd;
    wire        take_wr;
    wire        wr_enable;
    wire        wr_status;
    wire        wr_mask;

    // Source pins cross into hclk before any gating
    nip_sync u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (irq_src),
        .sync_out (src_sync)
    );

    // Word select from byte address, upper bits ignored
    function [7:0] nip_word;
        input [31:0] a;
        begin
            nip_word = {a[7:2], 2'b00};
        end
    endfunction

    // Data-phase write hit on one register word
    function nip_hit;
        input       pend;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            nip_hit = pend & (addr == ofs);
        end
    endfunction

    // Write-one-to-clear; a set in the same cycle wins
    function [31:0] nip_w1c;
        input [31:0] cur;
        input [31:0] clr;
        input [31:0] set;
        begin
            nip_w1c = (cur & ~clr) | set;
        end
    endfunction

    // Any bit of a word set
    function nip_any;
        input [31:0] v;
        begin
            nip_any = |v;
        end
    endfunction

    // Live level, no latching of past events
    assign next_pending = src_sync & normal_enable;
    assign rise         = next_pending & ~normal_irq_pending;

    // Only NONSEQ and SEQ carry a transfer; BUSY and IDLE are ignored
    assign take    = hsel & hready &
                     (htrans == `NIP_HTRANS_NONSEQ | htrans == `NIP_HTRANS_SEQ);
    assign take_rd = take & ~hwrite;
    assign take_wr = take & hwrite;

    // Data-phase strobes; the pending word has none, so writes there vanish
    assign wr_enable = nip_hit(wr_pend, wr_addr, `NIP_OFS_ENABLE);
    assign wr_status = nip_hit(wr_pend, wr_addr, `NIP_OFS_STATUS);
    assign wr_mask   = nip_hit(wr_pend, wr_addr, `NIP_OFS_MASK);

    // Address kept only for a taken transfer
    always @* begin
        next_wr_pend = take_wr;
        next_wr_addr = wr_addr;
        if (take) begin
            next_wr_addr = nip_word(haddr);
        end
    end

    // Software registers take the data-phase word
    always @* begin
        next_enable = normal_enable;
        next_mask   = irq_mask;
        if (wr_enable) begin
            next_enable = hwdata;
        end
        if (wr_mask) begin
            next_mask = hwdata;
        end
    end

    // Sticky status on a new pending flag
    always @* begin
        if (wr_status) begin
            next_status = nip_w1c(irq_status, hwdata, rise);
        end else begin
            next_status = nip_w1c(irq_status, 32'h0000_0000, rise);
        end
    end

    // Reads return the value after this edge, so a back-to-back write is seen
    always @* begin
        next_hrdata = hrdata;
        if (take_rd) begin
            case (nip_word(haddr))
                `NIP_OFS_PENDING: next_hrdata = next_pending;
                `NIP_OFS_ENABLE:  next_hrdata = next_enable;
                `NIP_OFS_STATUS:  next_hrdata = next_status;
                `NIP_OFS_MASK:    next_hrdata = next_mask;
                default:          next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    // Request level ahead of its output flop
    always @* begin
        next_req = nip_any(next_pending);
    end

    // Interrupt level from unmasked status
    always @* begin
        next_irq = nip_any(irq_status & irq_mask);
    end

    // Pending flags and request share one edge
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            normal_irq_pending <= `NIP_RST_PENDING;
            normal_irq_req     <= 1'b0;
        end else begin
            normal_irq_pending <= next_pending;
            normal_irq_req     <= next_req;
        end
    end

    // Bus handshake; zero wait states and always OKAY
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend   <= next_wr_pend;
            wr_addr   <= next_wr_addr;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Read data holds until the next read is taken
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else begin
            hrdata <= next_hrdata;
        end
    end

    // Software and status registers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            normal_enable <= `NIP_RST_ENABLE;
            irq_mask      <= `NIP_RST_MASK;
            irq_status    <= `NIP_RST_STATUS;
        end else begin
            normal_enable <= next_enable;
            irq_mask      <= next_mask;
            irq_status    <= next_status;
        end
    end

    // Level interrupt output flop
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end
endmodule // nip_top
`default_nettype wire

/* File: sim/nip_asserts.sv */
// Port checker for the normal pending block
`timescale 1ns/1ps
`default_nettype none
module nip_asserts (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic [31:0] hrdata,
    input wire logic [31:0] irq_src,
    input wire logic        normal_irq_req
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence quiet; (irq_src == 32'h0000_0000) [*4]; endsequence // Flushes sync path
    AST_QUIET: assert property (quiet |-> !normal_irq_req) else $error("idle request");
    AST_CAUSE: assert property (normal_irq_req |-> |($past(irq_src, 3) | $past(irq_src, 4)))
        else $error("request without source");
    AST_RISE: assert property ($rose(normal_irq_req) |-> $past(irq_src, 3) != 0)
        else $error("request rose early");
    AST_RST_DATA: assert property ($rose(hresetn) |-> hrdata == 0) else $error("hrdata");
    AST_RST_REQ: assert property ($rose(hresetn) |-> !normal_irq_req) else $error("req");
endmodule // nip_asserts
bind nip_top nip_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hrdata(hrdata),
    .irq_src(irq_src), .normal_irq_req(normal_irq_req));
`default_nettype wire

/* File: sim/nip_core.sv */
// Core-side model of the normal request input
`timescale 1ns/1ps
`default_nettype none
module nip_core (
    input wire logic hclk,
    input wire logic req,
    output var int   seen
);
    int count = 0;

    // Level input with no acknowledge, so the core only counts request cycles
    always @(posedge hclk) if (req === 1'b1) count <= count + 1;
    assign seen = count;
endmodule // nip_core
`default_nettype wire

/* File: sim/tb.sv */
// Bench for the normal pending block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rdy, resp, req, irq;
    logic [1:0]  htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, src = 0, hrdata;
    int          mismatches = 0, samples_checked = 0, seen, s0;
    nip_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hrdata(hrdata),
        .hreadyout(rdy), .hresp(resp), .irq_src(src), .normal_irq_req(req), .irq(irq));
    nip_core CORE (.hclk(hclk), .req(req), .seen(seen));
    initial forever #25 hclk = ~hclk;
    task chk(string n, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) $display("ERROR %s expected %h seen %h", n, e, g);
        mismatches += (g !== e);
    endtask
    // Single word transfer; reads compare against d, both phases held until ready
    task bus(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr} <= {3'b110, w, 24'h00_0000, a};
        do @(posedge hclk); while (rdy !== 1'b1);
        {hsel, htrans, hwdata} <= {3'b000, d};
        do @(posedge hclk); while (rdy !== 1'b1);
        chk("response", 0, resp);
        if (!w) chk("read data", d, hrdata);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #60us mismatches++;
        give_verdict;
    end
    // Levels are compared at falling edges, away from register updates, except cleared irq, checked at the rising edge that ends a bus read
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 5; i++) bus(1'b0, 8'(4 * i), 0);
        bus(1'b1, 8'h00, 32'hFFFF_FFFF);
        bus(1'b0, 8'h00, 0);
        bus(1'b0, 8'h04, 0);
        src <= 32'h8000_0003;
        repeat (4) @(negedge hclk);
        chk("request disabled", 0, req);
        bus(1'b1, 8'h04, 32'h8000_0001);
        bus(1'b0, 8'h04, 32'h8000_0001);
        repeat (2) @(negedge hclk);
        chk("request", 1, req);
        chk("masked irq", 0, irq);
        s0 = seen;
        repeat (10) @(negedge hclk);
        chk("core request cycles", s0 + 10, seen);
        bus(1'b0, 8'h00, 32'h8000_0001);
        bus(1'b0, 8'h08, 32'h8000_0001);
        bus(1'b1, 8'h0C, 32'hFFFF_FFFF);
        src <= 0;
        repeat (4) @(negedge hclk);
        chk("request off", 0, req);
        chk("irq", 1, irq);
        bus(1'b0, 8'h00, 0);
        bus(1'b1, 8'h08, 32'hFFFF_FFFF);
        bus(1'b0, 8'h08, 0);
        chk("cleared irq", 0, irq);
        // Mid-run reset with a source live and enabled
        src <= 32'h0000_0001;
        repeat (4) @(negedge hclk);
        chk("request before reset", 1, req);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk("request after reset", 0, req);
        bus(1'b0, 8'h00, 0);
        bus(1'b0, 8'h04, 0);
        give_verdict;
    end
endmodule // tb
`default_nettype wire
